/* verilog/ipwt_pkg.sv */
// shared constants, field layouts, carriers and helpers for the program word transfer card
package ipwt_pkg;
	localparam int CLK_MHZ = 200;
	localparam int OSC_MHZ = 10;
	localparam int TICK_DIV = CLK_MHZ / OSC_MHZ;
	localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);
	localparam int MAG_W = 16;
	localparam int CTL_W = 8;
	localparam logic [3:0] BIT_LAST = 4'hf;
	localparam int STBY_BIT = 7;
	// fixed one-shot lengths, in 10 MHz ticks
	localparam logic [7:0] LOAD_TICKS = 8'h02;
	localparam logic [7:0] STBY_TICKS = 8'h20;
	localparam logic [7:0] CL_TICKS = 8'h08;
	// register offsets (byte addresses)
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_LEN = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_MAG = 8'h0c;
	localparam logic [7:0] REG_CTL = 8'h10;
	// configuration bit positions and reset value
	localparam int CFG_DUAL = 0;
	localparam int CFG_BIN = 1;
	localparam int CFG_ASYNC = 2;
	localparam logic [2:0] CFG_RST = 3'h0;
	// length register field positions and reset value
	localparam int LEN_HOLD1 = 0;
	localparam int LEN_HOLD2 = 8;
	localparam int LEN_NRDY = 16;
	localparam int LEN_LATCH = 24;
	localparam logic [31:0] LEN_RST = 32'h14181404;

	typedef struct packed {
		logic [MAG_W-1:0] mag;
		logic [CTL_W-1:0] ctl;
		logic ctl_strobe;
		logic mag_strobe;
		logic frame_sel;
		logic steer;
		logic sign_neg;
		logic standby_req;
		logic status_en;
		logic supply_ok;
	} ipwt_prog_in_s;

	typedef struct packed {
		logic not_ready;
		logic abnormal;
		logic cl_flag;
		logic cl_oe_n;
		logic pf_flag;
		logic pf_oe_n;
	} ipwt_prog_out_s;

	typedef struct packed {
		logic [MAG_W-1:0] mag;
		logic [CTL_W-1:0] ctl;
		logic hold;
		logic standby;
	} ipwt_psrc_s;

	// one-shot counter step: trigger reloads, tick counts down to zero
	function automatic logic [7:0] os_next(input logic [7:0] cnt, input logic trig,
		input logic [7:0] len, input logic tick);
		if (trig) begin
			return len;
		end else if (tick && cnt != 8'h00) begin
			return cnt - 8'h01;
		end
		return cnt;
	endfunction

	// trailing edge of a one-shot
	function automatic logic os_end(input logic [7:0] cnt, input logic tick);
		return tick && cnt == 8'h01;
	endfunction
endpackage

/* verilog/ipwt_iso.sv */
// isolated-side receive registers, control double buffer, hold and standby detect
`timescale 1ns/1ps
`default_nettype none
module ipwt_iso import ipwt_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic bclk,
	input wire logic mag_bit,
	input wire logic ctl_bit,
	input wire logic hold_trig,
	input wire logic [7:0] hold_len,
	input wire logic latch_load,
	input wire logic stby_pulse,
	input wire logic async_mode,
	input wire logic cl_flag_in,
	output logic cl_osc,
	output ipwt_psrc_s psrc
);
	logic [MAG_W-1:0] mag_rx_ff;
	logic [CTL_W-1:0] ctl_rx_ff, ctl_lat_ff;
	logic [7:0] hold2_ff, sb_ff;
	logic cl_s1_ff, cl_s2_ff, osc_ff, hold_ff, stby_ff;
	logic [7:0] nxt_hold2, nxt_sb;
	logic nxt_stby;

	assign nxt_hold2 = os_next(hold2_ff, hold_trig, hold_len, tick); // R23
	assign nxt_sb = os_next(sb_ff, stby_pulse, STBY_TICKS, tick);
	// sync mode takes standby from the latched word, async from the rectified pulse train
	assign nxt_stby = async_mode ? (nxt_sb != 8'h00) : ctl_lat_ff[STBY_BIT]; // R16 R17
	assign cl_osc = osc_ff;
	assign psrc = '{mag: mag_rx_ff, ctl: ctl_lat_ff, hold: hold_ff, standby: stby_ff};

	// capture on the coupled clock; latch only at the latch load pulse
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mag_rx_ff <= '0;
			ctl_rx_ff <= '0;
			ctl_lat_ff <= '0;
		end else begin
			if (bclk) begin
				mag_rx_ff <= {mag_bit, mag_rx_ff[MAG_W-1:1]}; // R6
				ctl_rx_ff <= {ctl_bit, ctl_rx_ff[CTL_W-1:1]}; // R6
			end
			if (latch_load) begin
				ctl_lat_ff <= ctl_rx_ff; // R10
			end
		end
	end

	// hold one-shot, standby detector and current-limit oscillator
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hold2_ff <= 8'h00;
			sb_ff <= 8'h00;
			hold_ff <= 1'b0;
			stby_ff <= 1'b0;
			cl_s1_ff <= 1'b0;
			cl_s2_ff <= 1'b0;
			osc_ff <= 1'b0;
		end else begin
			hold2_ff <= nxt_hold2;
			sb_ff <= nxt_sb;
			hold_ff <= nxt_hold2 != 8'h00;
			stby_ff <= nxt_stby;
			cl_s1_ff <= cl_flag_in;
			cl_s2_ff <= cl_s1_ff;
			osc_ff <= (tick && cl_s2_ff) ? ~osc_ff : osc_ff; // R18
		end
	end
endmodule
`default_nettype wire

/* verilog/ipwt_top.sv */
// outer-side transfer control, serial shift path, status return and register port
//
// Function
// (R1) any word load fires first hold pulse
// (R2) strobes count only with frame select
// (R3) steering line routes single strobe
// (R4) hold trailing edge sets transfer flag
// (R5) transfer flag runs and gates pulses
// (R6) each pulse shifts one bit across
// (R7) sixteenth pulse carry ends the transfer
// (R8) magnitude register recirculates back into place
// (R9) control word crosses twice in sixteen
// (R10) isolated control word is double buffered
// (R11) first pulse starts latch timing load
// (R12) complementing only for binary power source
// (R13) negative sign selects complemented serial path
// (R14) complement flag sets after first one
// (R15) carry clears the complement flag
// (R16) sync standby rides in control word
// (R17) async standby runs clock, feeds standby
// (R18) current limit oscillator drives abnormal status
// (R19) current limit flag driven when status-enabled
// (R20) supply loss raises power fail indication
// (R21) hold trailing edge starts not ready
// (R22) source issues no strobe while not ready
// (R23) isolated hold length is configurable
// (R24) one-shots count 10 MHz ticks, configurable; load, standby and current-limit lengths are fixed
`timescale 1ns/1ps
`default_nettype none
module ipwt_top import ipwt_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire ipwt_prog_in_s prog_in,
	input wire logic cl_flag_in,
	output ipwt_prog_out_s prog_out,
	output ipwt_psrc_s psrc_out
);
	ipwt_prog_in_s pin_s1_ff, pin_s2_ff, pin_d_ff;
	ipwt_prog_out_s out_ff, nxt_out;
	logic [4:0] div_ff;
	logic [2:0] cfg_ff;
	logic [31:0] len_ff, rdata_ff;
	logic [7:0] load_ff, hold1_ff, nrdy_ff, latch_ff, cldet_ff;
	logic [7:0] nxt_load, nxt_hold1, nxt_nrdy, nxt_latch, nxt_cldet;
	logic [3:0] bit_cnt_ff;
	logic [MAG_W-1:0] mag_sr_ff, mag_snap_ff;
	logic [CTL_W-1:0] ctl_snap_ff;
	logic [CTL_W-1:0] ctl_sr_ff;
	logic xfer_ff, comp_ff, osc_d_ff;
	logic nxt_xfer, nxt_comp;

	// the oscillator is modelled free running; "clock running" gates its ticks
	wire tick = div_ff == TICK_LAST;
	wire dual = cfg_ff[CFG_DUAL];
	wire bin_type = cfg_ff[CFG_BIN];
	wire async_sb = cfg_ff[CFG_ASYNC];
	wire [7:0] hold1_len = len_ff[LEN_HOLD1 +: 8];
	wire [7:0] hold2_len = len_ff[LEN_HOLD2 +: 8];
	wire [7:0] nrdy_len = len_ff[LEN_NRDY +: 8];
	wire [7:0] latch_len = len_ff[LEN_LATCH +: 8];

	// strobe qualification and steering
	wire ctl_edge = pin_s2_ff.ctl_strobe && !pin_d_ff.ctl_strobe;
	wire mag_edge = pin_s2_ff.mag_strobe && !pin_d_ff.mag_strobe;
	wire fsel = pin_s2_ff.frame_sel;
	wire ctl_trig = fsel && ctl_edge && (dual || !pin_s2_ff.steer); // R2 R3
	wire mag_trig = fsel && (dual ? mag_edge : (ctl_edge && pin_s2_ff.steer)); // R2 R3
	wire load_any = ctl_trig || mag_trig;

	// transfer timing
	wire hold1_end = os_end(hold1_ff, tick);
	wire latch_end = os_end(latch_ff, tick);
	wire shift_pulse = tick && xfer_ff; // R5
	wire carry = shift_pulse && bit_cnt_ff == BIT_LAST; // R7
	wire first_pulse = shift_pulse && bit_cnt_ff == 4'h0;
	wire clk_run = xfer_ff || (async_sb && pin_s2_ff.standby_req); // R5 R7 R17
	// sign_path_selector: complement path only for a binary source with negative sign
	wire sign_path_selector = bin_type && pin_s2_ff.sign_neg; // R12 R13
	wire mag_bit = mag_sr_ff[0] ^ (sign_path_selector && comp_ff); // R13
	wire ctl_bit = ctl_sr_ff[0];
	// standby_clock_coupler: pulses reach it only between transfers
	wire standby_clock_coupler = tick && clk_run && async_sb && !xfer_ff; // R17
	wire barrier_clock_coupler = shift_pulse; // R6
	wire power_fail = !pin_s2_ff.supply_ok; // R20
	wire complement_and_status_coupler;
	wire cl_det = cldet_ff != 8'h00;

	assign nxt_load = os_next(load_ff, load_any, LOAD_TICKS, tick); // R24
	assign nxt_hold1 = os_next(hold1_ff, load_any, hold1_len, tick); // R1 R24
	assign nxt_nrdy = os_next(nrdy_ff, hold1_end, nrdy_len, tick); // R21 R24
	assign nxt_latch = os_next(latch_ff, first_pulse, latch_len, tick); // R11 R24
	assign nxt_cldet = os_next(cldet_ff, complement_and_status_coupler ^ osc_d_ff,
		CL_TICKS, tick); // R18
	// carry has priority so the flags end cleanly on the sixteenth pulse
	assign nxt_xfer = carry ? 1'b0 : (hold1_end ? 1'b1 : xfer_ff); // R4 R7
	assign nxt_comp = carry ? 1'b0 : ((shift_pulse && mag_sr_ff[0]) ? 1'b1 : comp_ff); // R14 R15

	// status outputs; flag pins are driven only while status-enabled
	assign nxt_out = '{not_ready: nxt_nrdy != 8'h00,
		abnormal: cl_det || power_fail,
		cl_flag: cl_det,
		cl_oe_n: !pin_s2_ff.status_en,
		pf_flag: power_fail,
		pf_oe_n: !pin_s2_ff.status_en}; // R18 R19 R20 R21
	assign prog_out = out_ff;
	assign reg_rdata = rdata_ff;

	// register read selection; unmapped offsets read zero
	wire [31:0] stat_word = {22'h0, psrc_out.standby, psrc_out.hold, cl_det, power_fail,
		clk_run, load_ff != 8'h00, nrdy_ff != 8'h00, hold1_ff != 8'h00, comp_ff, xfer_ff};
	wire [31:0] rd_word = (reg_addr == REG_CFG) ? {29'h0, cfg_ff} :
		(reg_addr == REG_LEN) ? len_ff :
		(reg_addr == REG_STAT) ? stat_word :
		(reg_addr == REG_MAG) ? {16'h0, psrc_out.mag} :
		(reg_addr == REG_CTL) ? {24'h0, psrc_out.ctl} : 32'h0;

	// pin synchronisers, the delayed copy serves the strobe edge detect
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_d_ff <= '0;
			// supply present is the pin's idle level; a zero here reads as a false power fail
			pin_s1_ff.supply_ok <= 1'b1;
			pin_s2_ff.supply_ok <= 1'b1;
		end else begin
			pin_s1_ff <= prog_in;
			pin_s2_ff <= pin_s1_ff;
			pin_d_ff <= pin_s2_ff;
		end
	end

	// register port; read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cfg_ff <= CFG_RST;
			len_ff <= LEN_RST;
			rdata_ff <= 32'h0;
		end else begin
			if (reg_wr && reg_addr == REG_CFG) begin
				cfg_ff <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == REG_LEN) begin
				len_ff <= reg_wdata;
			end
			rdata_ff <= reg_rd ? rd_word : 32'h0;
		end
	end

	// oscillator divider and one-shot timers
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			div_ff <= 5'h0;
			load_ff <= 8'h00;
			hold1_ff <= 8'h00;
			nrdy_ff <= 8'h00;
			latch_ff <= 8'h00;
			cldet_ff <= 8'h00;
			osc_d_ff <= 1'b0;
			out_ff <= '{default: 1'b0, cl_oe_n: 1'b1, pf_oe_n: 1'b1};
		end else begin
			div_ff <= tick ? 5'h0 : div_ff + 5'h1;
			load_ff <= nxt_load;
			hold1_ff <= nxt_hold1;
			nrdy_ff <= nxt_nrdy;
			latch_ff <= nxt_latch;
			cldet_ff <= nxt_cldet;
			osc_d_ff <= complement_and_status_coupler;
			out_ff <= nxt_out;
		end
	end

	// transfer flag, pulse counter and complement flag
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			xfer_ff <= 1'b0;
			comp_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
		end else begin
			xfer_ff <= nxt_xfer;
			comp_ff <= nxt_comp;
			if (shift_pulse) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1; // R7
			end
		end
	end

	// outer recirculating shift registers; load wins, a strobe mid-transfer is illegal anyway
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mag_sr_ff <= '0;
			ctl_sr_ff <= '0;
			mag_snap_ff <= '0;
			ctl_snap_ff <= '0;
		end else begin
			if (mag_trig) begin
				mag_sr_ff <= pin_s2_ff.mag;
			end else if (shift_pulse) begin
				mag_sr_ff <= {mag_sr_ff[0], mag_sr_ff[MAG_W-1:1]}; // R8
			end
			if (ctl_trig) begin
				ctl_sr_ff <= pin_s2_ff.ctl;
				if (!async_sb) begin
					ctl_sr_ff[STBY_BIT] <= pin_s2_ff.standby_req; // R16
				end
			end else if (shift_pulse) begin
				ctl_sr_ff <= {ctl_sr_ff[0], ctl_sr_ff[CTL_W-1:1]}; // R9
			end
			if (hold1_end) begin
				mag_snap_ff <= mag_sr_ff;
				ctl_snap_ff <= ctl_sr_ff;
			end
		end
	end

	ipwt_iso u_iso (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(tick),
		.bclk(barrier_clock_coupler),
		.mag_bit(mag_bit),
		.ctl_bit(ctl_bit),
		.hold_trig(load_any),
		.hold_len(hold2_len),
		.latch_load(latch_end),
		.stby_pulse(standby_clock_coupler),
		.async_mode(async_sb),
		.cl_flag_in(cl_flag_in),
		.cl_osc(complement_and_status_coupler),
		.psrc(psrc_out)
	);

	// per-transfer pulse tally for the checks, kept apart from the design's own counter
	logic [4:0] pulse_tot_ff;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pulse_tot_ff <= 5'h00;
		end else if (hold1_end) begin
			pulse_tot_ff <= 5'h00;
		end else if (shift_pulse) begin
			pulse_tot_ff <= pulse_tot_ff + 5'h01;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_hold_end;
		hold1_end;
	endsequence

	sequence s_xfer_done;
		$fell(xfer_ff);
	endsequence

	// a strobe edge while the unit is not addressed and no hold is running
	sequence s_unaddressed;
		(ctl_edge || mag_edge) && !fsel && hold1_ff == 8'h00;
	endsequence

	// strobe qualification and steering
	frame_gate_a: assert property (s_unaddressed |=> hold1_ff == 8'h00) // R2
		else $error("unaddressed strobe started a hold pulse");

	steer_route_a: assert property (fsel && ctl_edge && !dual && pin_s2_ff.steer // R3
		|-> mag_trig && !ctl_trig)
		else $error("steered strobe did not reach magnitude load");

	ctl_route_a: assert property (fsel && ctl_edge && !dual && !pin_s2_ff.steer // R3
		|-> ctl_trig && !mag_trig)
		else $error("steered strobe did not reach control load");

	dual_route_a: assert property (fsel && mag_edge && dual |-> mag_trig) // R3
		else $error("magnitude strobe ignored in dual mode");

	// transfer sequencing
	hold_start_a: assert property (load_any && hold1_len != 8'h00 |=> hold1_ff == hold1_len) // R1
		else $error("load did not start hold pulse");

	xfer_set_a: assert property (s_hold_end |=> xfer_ff) // R4
		else $error("transfer flag not set at hold end");

	nrdy_start_a: assert property (s_hold_end ##1 (nrdy_len != 8'h00) |=> out_ff.not_ready) // R21
		else $error("not ready missing after hold end");

	xfer_stop_a: assert property (s_xfer_done |-> $past(carry)) // R7
		else $error("transfer ended without carry");

	pulse_total_a: assert property (s_xfer_done |-> pulse_tot_ff == 5'(MAG_W)) // R7
		else $error("transfer did not run sixteen pulses");

	idle_count_a: assert property (!xfer_ff |=> $stable(bit_cnt_ff)) // R5 R17
		else $error("pulse counter moved while idle");

	idle_mag_a: assert property (!xfer_ff && !mag_trig |=> $stable(mag_sr_ff)) // R5
		else $error("magnitude register moved while idle");

	// serial data path
	rotate_home_a: assert property (s_xfer_done |-> mag_sr_ff == mag_snap_ff) // R8
		else $error("magnitude word not back in place");

	ctl_home_a: assert property (s_xfer_done |-> ctl_sr_ff == ctl_snap_ff) // R9
		else $error("control word not back in place");

	first_plain_a: assert property (first_pulse |-> !comp_ff) // R14
		else $error("first serial bit complemented");

	comp_set_a: assert property (shift_pulse && mag_sr_ff[0] && !carry |=> comp_ff) // R14
		else $error("complement flag missed first one bit");

	comp_clear_a: assert property (carry |=> !comp_ff && !xfer_ff) // R15
		else $error("complement flag survived carry");

	sync_stby_a: assert property (ctl_trig && !async_sb // R16
		|=> ctl_sr_ff[STBY_BIT] == $past(pin_s2_ff.standby_req))
		else $error("standby bit not carried in control word");

	// control double buffer and isolated hold
	latch_start_a: assert property (first_pulse && latch_len != 8'h00 // R11
		|=> latch_ff == latch_len)
		else $error("latch timing not started");

	latch_keep_a: assert property (!latch_end |=> $stable(psrc_out.ctl)) // R10
		else $error("control word changed outside latch load");

	hold_iso_a: assert property (load_any && hold2_len != 8'h00 |=> psrc_out.hold) // R1 R23
		else $error("isolated hold not started by load");

	// status return
	flag_drive_a: assert property (!pin_s2_ff.status_en |=> out_ff.cl_oe_n && out_ff.pf_oe_n) // R19
		else $error("flag driven without status enable");

	flag_enable_a: assert property (pin_s2_ff.status_en // R19
		|=> !out_ff.cl_oe_n && !out_ff.pf_oe_n)
		else $error("flag not driven under status enable");

	pwr_fail_a: assert property (power_fail |=> out_ff.abnormal) // R20
		else $error("power fail not on abnormal status");

	pf_output_a: assert property (power_fail && pin_s2_ff.status_en // R20
		|=> out_ff.pf_flag && !out_ff.pf_oe_n)
		else $error("power fail flag not driven");
endmodule
`default_nettype wire

/* tb/ipwt_src_model.sv */
// program source model: parallel words, strobes, status address and supply level
`timescale 1ns/1ps
`default_nettype none
module ipwt_src_model import ipwt_pkg::*; (
	input wire logic sys_clk,
	input wire logic not_ready,
	output ipwt_prog_in_s prog_in
);
	initial begin
		prog_in = '0;
		prog_in.supply_ok = 1'b1;
	end

	// words and sign stay on the pins after the strobe, since sign is read live
	task automatic strobe(input logic on_mag, input logic st, input logic [15:0] m,
		input logic [7:0] c, input logic neg, input logic fs);
		int n;
		n = 0;
		while (not_ready !== 1'b0 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		prog_in.mag <= m;
		prog_in.ctl <= c;
		prog_in.steer <= st;
		prog_in.sign_neg <= neg;
		prog_in.frame_sel <= fs;
		// settle address and steering before the strobe edge reaches the synchroniser
		repeat (3) @(posedge sys_clk);
		if (on_mag) prog_in.mag_strobe <= 1'b1;
		else prog_in.ctl_strobe <= 1'b1;
		repeat (6) @(posedge sys_clk);
		prog_in.mag_strobe <= 1'b0;
		prog_in.ctl_strobe <= 1'b0;
		repeat (2) @(posedge sys_clk);
		prog_in.frame_sel <= 1'b0;
	endtask

	// status address, supply level and standby request
	task automatic set_stat(input logic se, input logic sok, input logic sreq);
		@(posedge sys_clk);
		prog_in.status_en <= se;
		prog_in.supply_ok <= sok;
		prog_in.standby_req <= sreq;
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the program word transfer card
`timescale 1ns/1ps
`default_nettype none
module testbench import ipwt_pkg::*;;
	logic sys_clk;
	logic rstn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	ipwt_prog_in_s prog_in;
	logic cl_flag_in;
	ipwt_prog_out_s prog_out;
	ipwt_psrc_s psrc_out;
	int error_cnt = 0;
	int checks = 0;
	int hold_cyc;
	logic busy, held, ctl_kept;
	logic [15:0] tv [4] = '{16'hfff0, 16'h0001, 16'h8000, 16'h0000};

	ipwt_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.prog_in(prog_in), .cl_flag_in(cl_flag_in), .prog_out(prog_out),
		.psrc_out(psrc_out));
	ipwt_src_model src_u (.sys_clk(sys_clk), .not_ready(prog_out.not_ready),
		.prog_in(prog_in));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// hold width counter, cleared by the test before each measurement
	always @(posedge sys_clk) if (psrc_out.hold === 1'b1) hold_cyc++;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("counts: %0d checks, %0d mismatches", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, e);
	endtask

	// one strobe, then wait out the busy window; bounded so an ignored strobe ends too
	task automatic go(input logic on_mag, input logic st, input logic [15:0] m,
		input logic [7:0] c, input logic neg, input logic fs);
		logic [7:0] c0;
		c0 = psrc_out.ctl;
		busy = 0;
		held = 0;
		ctl_kept = 1;
		src_u.strobe(on_mag, st, m, c, neg, fs);
		for (int n = 0; n < 600 && !busy; n++) begin
			@(posedge sys_clk);
			#1;
			if (psrc_out.hold === 1'b1) held = 1;
			if (prog_out.not_ready === 1'b1) busy = 1;
		end
		// the old control word must still be presented when shifting starts
		if (psrc_out.ctl !== c0) ctl_kept = 0;
		for (int n = 0; n < 2000 && busy && prog_out.not_ready !== 1'b0; n++)
			@(posedge sys_clk);
		repeat (30) @(posedge sys_clk);
	endtask

	initial begin
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cl_flag_in = 1'b0;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		#1 chk("out", {26'h0, prog_out}, 32'h5);
		chk("psrc", {6'h0, psrc_out}, 32'h0);
		rd(REG_CFG, {29'h0, CFG_RST});
		rd(REG_LEN, LEN_RST);
		rd(8'h3c, 32'h0);
		$display("test reset done");
		// single strobe: steering picks the word
		go(0, 1, 16'h1234, 8'h00, 0, 1);
		chk("hold", held, 1);
		chk("busy", busy, 1);
		chk("mag", psrc_out.mag, 16'h1234);
		rd(REG_MAG, 32'h1234);
		go(0, 0, 16'hffff, 8'h5a, 0, 1);
		chk("ctl kept", ctl_kept, 1);
		chk("ctl", psrc_out.ctl, 8'h5a);
		chk("mag", psrc_out.mag, 16'h1234);
		go(0, 1, 16'h4321, 8'h00, 0, 0);
		chk("busy", busy, 0);
		chk("mag", psrc_out.mag, 16'h1234);
		$display("test single strobe done");
		// dual strobe, then binary source with sign
		wr(REG_CFG, 32'h1);
		go(1, 0, 16'h00ff, 8'h00, 0, 1);
		chk("mag", psrc_out.mag, 16'h00ff);
		go(0, 1, 16'h0000, 8'h33, 0, 1);
		chk("ctl", psrc_out.ctl, 8'h33);
		go(1, 0, 16'hfff0, 8'h00, 1, 1);
		chk("mag", psrc_out.mag, 16'hfff0);
		wr(REG_CFG, 32'h3);
		rd(REG_CFG, 32'h3);
		for (int i = 0; i < 4; i++) begin
			go(1, 0, tv[i], 8'h00, 1, 1);
			chk("mag", psrc_out.mag, 16'(~tv[i] + 16'h1));
		end
		go(1, 0, 16'hfff0, 8'h00, 0, 1);
		chk("mag", psrc_out.mag, 16'hfff0);
		$display("test dual and sign done");
		// sync standby rides in bit 7; shorter isolated hold
		src_u.set_stat(0, 1, 1);
		go(0, 0, 16'h0, 8'h01, 0, 1);
		chk("ctl", psrc_out.ctl, 8'h81);
		rd(REG_CTL, 32'h81);
		wr(REG_LEN, 32'h14180804);
		hold_cyc = 0;
		go(1, 0, 16'h0, 8'h00, 0, 1);
		chk("hold len", hold_cyc >= 140 && hold_cyc <= 181, 1);
		$display("test standby sync and hold done");
		// async standby runs the pulses outside any transfer
		wr(REG_CFG, 32'h5);
		repeat (1000) @(posedge sys_clk);
		#1 chk("standby", psrc_out.standby, 1);
		chk("busy", prog_out.not_ready, 0);
		rd(REG_STAT, 32'h220);
		src_u.set_stat(0, 1, 0);
		repeat (1000) @(posedge sys_clk);
		#1 chk("standby", psrc_out.standby, 0);
		$display("test async standby done");
		// status return
		@(posedge sys_clk);
		cl_flag_in <= 1'b1;
		repeat (200) @(posedge sys_clk);
		#1 chk("abn", {prog_out.abnormal, prog_out.cl_oe_n}, 2'h3);
		src_u.set_stat(1, 1, 0);
		repeat (10) @(posedge sys_clk);
		#1 chk("cl", {prog_out.cl_flag, prog_out.cl_oe_n}, 2'h2);
		@(posedge sys_clk);
		cl_flag_in <= 1'b0;
		repeat (400) @(posedge sys_clk);
		#1 chk("abn", prog_out.abnormal, 0);
		src_u.set_stat(1, 0, 0);
		repeat (10) @(posedge sys_clk);
		#1 chk("pf", {prog_out.abnormal, prog_out.pf_flag, prog_out.pf_oe_n}, 3'h6);
		$display("test status done");
		close_out();
	end

	// watchdog: the sequence needs about 10500 cycles
	initial begin
		#400000;
		error_cnt++;
		close_out();
	end
endmodule
`default_nettype wire
